/* rtl/crc_calculation_unit.sv */
/*
 * CRC calculation unit: Wishbone classic slave, two-entry data buffer and a
 * byte-per-cycle CRC engine. Assumes one clock, an asynchronous active-low
 * reset and a master that keeps its request until it sees ack.
 */
// Our own choice: the Wishbone interface to the registers.
// Summary of operation
// R1: four polynomials: 8-bit, CCITT, 16-bit and 32-bit Ethernet.
// R2: control bits 1:0 pick 8-bit, CCITT, 16-bit, 32-bit for 00..11.
// R3: default seeds are 0x00, 0xffff, 0x0000 and 0xffffffff.
// R4: control bit 6 picks default seed (0) or the seed register (1).
// R5: writing 1 to control bit 7 loads the selected seed into the remainder.
// R6: control bit 5 complements the checksum seen on read.
// R7: control bit 4 reverses the bit order of the checksum seen on read.
// R8: control bit 3 complements every input byte before calculation.
// R9: control bit 2 reverses bits inside each input byte, keeping byte order.
// R10: 8-, 16-, 32-bit writes take 1, 2 or 4 cycles, one byte each.
// R11: back-to-back data writes are accepted from processor or DMA.
// R12: checksum reads wait until every pending byte is processed.
// R13: offset 0x08 reads the checksum and writes take data; data is write-only.
// R14: after reset control reads zero, seed reads 0x0000ffff; the checksum reads 0x000000ff, as reset control picks the 8-bit width.
// R15: 8- and 16-bit checksums sit in the low bits, upper bits zero.
// R16: multi-byte writes feed bytes from least to most significant.
// R17: result reflect and complement act on read only, over the CRC width.
`timescale 1ns/1ps
`include "crc_params.svh"

module crc_calculation_unit (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire crc_pkg::wb_req_type wb_req,
  output logic [31:0]             wb_rdata,
  output logic                    wb_ack
);
  import crc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers over the selected width

  function automatic logic [31:0] width_mask(input poly_sel_type p);
    case (p)
      poly_crc8:  width_mask = `MASK_W8;
      poly_crc32: width_mask = `MASK_W32;
      default:    width_mask = `MASK_W16;
    endcase
  endfunction
  function automatic logic [31:0] poly_value(input poly_sel_type p);
    case (p)
      poly_crc8:  poly_value = `POLY_CRC8;
      poly_ccitt: poly_value = `POLY_CCITT;
      poly_crc16: poly_value = `POLY_CRC16;
      default:    poly_value = `POLY_CRC32;
    endcase
  endfunction
  function automatic logic [31:0] default_seed(input poly_sel_type p);
    case (p)
      poly_crc8:  default_seed = `DEFSEED_CRC8;
      poly_ccitt: default_seed = `DEFSEED_CCITT;
      poly_crc16: default_seed = `DEFSEED_CRC16;
      default:    default_seed = `DEFSEED_CRC32;
    endcase
  endfunction
  // msb-first division of one byte into the remainder
  function automatic logic [31:0] crc_step(input logic [31:0] crc,
                                           input logic [7:0]  d,
                                           input poly_sel_type p);
    logic [31:0] c;
    logic [31:0] m;
    logic [31:0] top;
    logic        fb;
    c   = crc;
    m   = width_mask(p);
    top = (m >> 1) + 32'h00000001;
    for (int i = 7; i >= 0; i--)
    begin
      fb = ((c & top) != 32'h00000000) ^ d[i];
      c  = (c << 1) & m;
      if (fb)
        c = c ^ poly_value(p); // [R1]
    end
    crc_step = c;
  endfunction
  // bit reversal over the checksum width
  function automatic logic [31:0] reflect_width(input logic [31:0] v,
                                                input poly_sel_type p);
    logic [31:0] r;
    for (int i = 0; i < 32; i++)
      r[i] = v[31-i];
    case (p)
      poly_crc8:  reflect_width = r >> 24;
      poly_crc32: reflect_width = r;
      default:    reflect_width = r >> 16;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  ctrl_type      ctrl_ff;
  logic [31:0]   seed_ff;
  logic [31:0]   crc_ff;
  logic          ack_ff;
  logic [31:0]   rdata_ff;
  buf_entry_type entry_ff [2];
  logic          wr_ptr_ff;
  logic          rd_ptr_ff;
  logic [1:0]    cnt_ff;
  logic [3:0]    done_ff;
  logic          req;
  logic          take;
  logic          ok;
  logic          hit_ctrl;
  logic          hit_seed;
  logic          hit_sum;
  logic          seed_load;
  logic          push;
  logic          pop;
  logic          in_ready;
  logic          out_valid;
  ctrl_type      nxt_ctrl;
  buf_entry_type head;
  logic [3:0]    rem;
  logic [3:0]    lane_hot;
  logic [1:0]    lane;
  logic [7:0]    raw_byte;
  logic [7:0]    in_byte;
  logic [31:0]   mask;
  logic [31:0]   result_value;
  logic [31:0]   read_value;
  logic [31:0]   seed_pick;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and wait states

  assign req      = wb_req.cyc && wb_req.stb && !ack_ff;
  assign hit_ctrl = wb_req.adr == `OFS_CONTROL;
  assign hit_seed = wb_req.adr == `OFS_SEED;
  assign hit_sum  = wb_req.adr == `OFS_SUM;
  assign in_ready = cnt_ff != 2'd2;
  assign out_valid = cnt_ff != 2'd0;

  // control writes wait for an idle engine so mode and seed never change mid-word
  always_comb
  begin
    ok = 1'b1;
    if (hit_sum && wb_req.we)
      ok = in_ready;  // [R11]
    else if (hit_sum)
      ok = !out_valid; // [R12]
    else if (hit_ctrl && wb_req.we)
      ok = !out_valid;
  end

  assign take = req && ok;
  assign push = take && wb_req.we && hit_sum && (wb_req.sel != 4'h0);
  assign seed_load = take && wb_req.we && hit_ctrl && wb_req.dat[`BIT_SEED_LOAD];

  // struct order matches control bits 6:0, polynomial select in 1:0
  assign nxt_ctrl = ctrl_type'(wb_req.dat[`BIT_SEED_SRC:`POLY_LO]); // [R2]

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ack_ff <= 1'b0;
    else
      ack_ff <= take;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ctrl_ff <= ctrl_type'(`CONTROL_RESET); // [R14]
    else if (take && wb_req.we && hit_ctrl)
      ctrl_ff <= nxt_ctrl;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      seed_ff <= `SEED_RESET; // [R14]
    else if (take && wb_req.we && hit_seed)
      seed_ff <= wb_req.dat;
  end

  assign mask = width_mask(ctrl_ff.polynomial_select);

  // output transforms leave crc_ff untouched so a stream can continue
  always_comb
  begin
    result_value = crc_ff & mask; // [R15]
    if (ctrl_ff.invert_result)
      result_value = result_value ^ mask; // [R6] [R17]
    if (ctrl_ff.reflect_result)
      result_value = reflect_width(result_value, ctrl_ff.polynomial_select); // [R7]
  end

  always_comb
  begin
    read_value = 32'h00000000;
    if (hit_ctrl)
      read_value = {25'h0, ctrl_ff};
    else if (hit_seed)
      read_value = seed_ff;
    else if (hit_sum)
      read_value = result_value; // [R13]
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata_ff <= 32'h00000000;
    else if (take && !wb_req.we)
      rdata_ff <= read_value;
  end

  assign wb_ack   = ack_ff;
  assign wb_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // two-entry data buffer

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= !wr_ptr_ff;
      if (pop)
        rd_ptr_ff <= !rd_ptr_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // data lines hold no control state, so no reset is needed
  always_ff @(posedge clock)
  begin
    if (push)
      entry_ff[wr_ptr_ff] <= '{data: wb_req.dat, sel: wb_req.sel};
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte engine

  assign head = entry_ff[rd_ptr_ff];
  assign rem  = head.sel & ~done_ff;

  // lowest lane first
  always_comb
  begin
    casez (rem)
      4'b???1: lane = 2'd0; // [R16]
      4'b??10: lane = 2'd1;
      4'b?100: lane = 2'd2;
      4'b1000: lane = 2'd3;
      default: lane = 2'd0;
    endcase
  end

  assign lane_hot = 4'h1 << lane;
  assign pop      = out_valid && ((rem & ~lane_hot) == 4'h0);
  assign raw_byte = head.data[{lane, 3'b000} +: 8];

  always_comb
  begin
    in_byte = raw_byte;
    if (ctrl_ff.invert_input)
      in_byte = ~in_byte; // [R8]
    if (ctrl_ff.reflect_input_bytes)
      in_byte = {<<{in_byte}}; // [R9]
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      done_ff <= 4'h0;
    else if (pop)
      done_ff <= 4'h0;
    else if (out_valid)
      done_ff <= done_ff | lane_hot; // [R10]
  end

  assign seed_pick = nxt_ctrl.seed_source_select ?
                     (seed_ff & width_mask(nxt_ctrl.polynomial_select)) :
                     default_seed(nxt_ctrl.polynomial_select); // [R3] [R4]

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      crc_ff <= `SUM_RESET; // [R14]
    else if (seed_load)
      crc_ff <= seed_pick; // [R5]
    else if (out_valid)
      crc_ff <= crc_step(crc_ff, in_byte, ctrl_ff.polynomial_select); // [R10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_full_word_at_head;
    out_valid && head.sel == 4'hf && done_ff == 4'h0;
  endsequence

  sequence s_three_bytes_then_pop;
    !pop ##1 !pop ##1 !pop ##1 pop;
  endsequence

  property p_four_byte_word;
    s_full_word_at_head |-> s_three_bytes_then_pop;
  endproperty
  a_four_byte_word: assert property (p_four_byte_word) // [R10]
    else $error("32-bit word not processed in four cycles");
  property p_sum_read_waits;
    wb_ack && !wb_req.we && hit_sum |-> $past(cnt_ff) == 2'd0;
  endproperty
  a_sum_read_waits: assert property (p_sum_read_waits) // [R12]
    else $error("checksum read answered while bytes pending");
  property p_sum_read_value;
    take && !wb_req.we && hit_sum |=> wb_rdata == $past(result_value);
  endproperty
  a_sum_read_value: assert property (p_sum_read_value) // [R13]
    else $error("checksum read returned wrong value");
  property p_default_seed32;
    seed_load && !wb_req.dat[`BIT_SEED_SRC] && wb_req.dat[1:0] == 2'b11
      |=> crc_ff == 32'hffffffff;
  endproperty
  a_default_seed32: assert property (p_default_seed32) // [R3]
    else $error("32-bit default seed not loaded");
  property p_prog_seed;
    seed_load && wb_req.dat[`BIT_SEED_SRC] |=> crc_ff == ($past(seed_ff) & mask);
  endproperty
  a_prog_seed: assert property (p_prog_seed) // [R5]
    else $error("programmable seed not loaded");
  property p_narrow_result;
    ctrl_ff.polynomial_select != poly_crc32 |-> result_value[31:16] == 16'h0000;
  endproperty
  a_narrow_result: assert property (p_narrow_result) // [R15]
    else $error("narrow checksum has upper bits set");
  property p_invert_result;
    ctrl_ff.invert_result && !ctrl_ff.reflect_result
      |-> result_value == ((crc_ff & mask) ^ mask);
  endproperty
  a_invert_result: assert property (p_invert_result) // [R6]
    else $error("result complement wrong");
  property p_crc_hold;
    !out_valid && !seed_load |=> $stable(crc_ff);
  endproperty
  a_crc_hold: assert property (p_crc_hold) // [R17]
    else $error("remainder changed with no input");
  property p_data_accept;
    req && wb_req.we && hit_sum && in_ready |=> wb_ack;
  endproperty
  a_data_accept: assert property (p_data_accept) // [R11]
    else $error("data write not accepted with room in buffer");

endmodule

/* inc/crc_params.svh */
/*
 * Register map, field positions, reset values and polynomial constants of the
 * CRC calculation unit. Assumes byte addressing on a 32-bit register bus.
 */
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH

// register byte offsets
`define OFS_CONTROL      8'h00
`define OFS_SEED         8'h04
`define OFS_SUM          8'h08

// control register field positions
`define BIT_SEED_LOAD    7
`define BIT_SEED_SRC     6
`define BIT_INV_RESULT   5
`define BIT_REFL_RESULT  4
`define BIT_INV_INPUT    3
`define BIT_REFL_INPUT   2
`define POLY_HI          1
`define POLY_LO          0

// reset values
`define CONTROL_RESET    7'h00
`define SEED_RESET       32'h0000ffff
`define SUM_RESET        32'h0000ffff

// generator polynomials, implicit top term left out
`define POLY_CRC8        32'h00000007
`define POLY_CCITT       32'h00001021
`define POLY_CRC16       32'h00008005
`define POLY_CRC32       32'h04c11db7

// default starting remainders
`define DEFSEED_CRC8     32'h00000000
`define DEFSEED_CCITT    32'h0000ffff
`define DEFSEED_CRC16    32'h00000000
`define DEFSEED_CRC32    32'hffffffff

// checksum width masks
`define MASK_W8          32'h000000ff
`define MASK_W16         32'h0000ffff
`define MASK_W32         32'hffffffff

`endif

/* inc/crc_pkg.sv */
/*
 * Types shared by the CRC calculation unit and its bench.
 * Assumes a classic Wishbone master with 32-bit data and 8-bit byte address.
 */
package crc_pkg;

  typedef enum logic [1:0] {
    poly_crc8  = 2'b00,
    poly_ccitt = 2'b01,
    poly_crc16 = 2'b10,
    poly_crc32 = 2'b11
  } poly_sel_type;

  typedef struct packed {
    logic         seed_source_select;
    logic         invert_result;
    logic         reflect_result;
    logic         invert_input;
    logic         reflect_input_bytes;
    poly_sel_type polynomial_select;
  } ctrl_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
  } wb_req_type;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  sel;
  } buf_entry_type;

endpackage

/* dv/crc_bus_writer.sv */
/*
 * Wishbone classic master standing in for the processor or DMA writer.
 * Assumes a slave that answers every request with a one-cycle ack.
 */
`timescale 1ns/1ps

module crc_bus_writer (
  input  wire logic          clock,
  output crc_pkg::wb_req_type wb_req,
  input  wire logic [31:0]   wb_rdata,
  input  wire logic          wb_ack
);
  import crc_pkg::*;

  initial
  begin
    wb_req = '0;
  end

  // no bound on the wait; the bench watchdog ends a hang
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel, output logic [31:0] rd);
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, dat: dat, sel: sel};
    do
      @(posedge clock);
    while (wb_ack !== 1'b1);
    rd = wb_rdata;
    // released lines invert so stale data never looks fresh
    wb_req <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, dat: ~dat, sel: ~sel};
  endtask
endmodule

/* dv/crc_calculation_unit_tb.sv */
/*
 * Self-checking bench of the CRC calculation unit with a reference model.
 * Assumes the bus writer model as the only master on the register bus.
 */
`timescale 1ns/1ps
`include "crc_params.svh"

module crc_calculation_unit_tb;
  import crc_pkg::*;

  logic        clock;
  logic        nrst;
  wb_req_type  wb_req;
  logic [31:0] wb_rdata;
  logic        wb_ack;
  int          n_errors;
  int          tests_run;
  logic [31:0] m_rem;
  logic [31:0] m_seed;
  logic [7:0]  m_ctrl;

  crc_calculation_unit i_crc_calculation_unit (
    .clock   (clock),
    .nrst    (nrst),
    .wb_req  (wb_req),
    .wb_rdata(wb_rdata),
    .wb_ack  (wb_ack)
  );

  crc_bus_writer i_crc_bus_writer (
    .clock   (clock),
    .wb_req  (wb_req),
    .wb_rdata(wb_rdata),
    .wb_ack  (wb_ack)
  );

  always #4 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  function automatic int wid(logic [1:0] p);
    return (p == 2'b00) ? 8 : (p == 2'b11) ? 32 : 16;
  endfunction

  function automatic logic [31:0] msk(logic [1:0] p);
    return (p == 2'b00) ? `MASK_W8 : (p == 2'b11) ? `MASK_W32 : `MASK_W16;
  endfunction

  function automatic logic [31:0] gen(logic [1:0] p);
    return (p == 2'b00) ? `POLY_CRC8 : (p == 2'b01) ? `POLY_CCITT :
           (p == 2'b10) ? `POLY_CRC16 : `POLY_CRC32;
  endfunction

  function automatic logic [31:0] dseed(logic [1:0] p);
    return (p == 2'b00) ? `DEFSEED_CRC8 : (p == 2'b01) ? `DEFSEED_CCITT :
           (p == 2'b10) ? `DEFSEED_CRC16 : `DEFSEED_CRC32;
  endfunction

  task automatic feed(input logic [7:0] b);
    logic [7:0] x;
    int         w;
    x = m_ctrl[3] ? ~b : b;
    if (m_ctrl[2])
      x = {<<{x}};
    w = wid(m_ctrl[1:0]);
    m_rem = m_rem ^ (32'(x) << (w - 8));
    for (int i = 0; i < 8; i++)
      m_rem = (m_rem[w-1] ? ((m_rem << 1) ^ gen(m_ctrl[1:0])) : (m_rem << 1))
              & msk(m_ctrl[1:0]);
  endtask

  function automatic logic [31:0] sum_exp();
    logic [31:0] r;
    r = m_rem & msk(m_ctrl[1:0]);
    if (m_ctrl[4])
      r = {<<{r}};
    if (m_ctrl[4])
      r = r >> (32 - wid(m_ctrl[1:0]));
    if (m_ctrl[5])
      r = ~r & msk(m_ctrl[1:0]);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] v;
    i_crc_bus_writer.xfer(1'b1, a, d, s, v);
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    i_crc_bus_writer.xfer(1'b0, a, 32'h0, 4'hf, v);
  endtask

  task automatic mode(input logic [7:0] c);
    bus_wr(`OFS_CONTROL, {24'h0, c}, 4'hf);
    m_ctrl = {1'b0, c[6:0]};
    if (c[7])
      m_rem = c[6] ? (m_seed & msk(c[1:0])) : dseed(c[1:0]);
  endtask

  // lanes go in lowest first
  task automatic dw(input logic [31:0] d, input logic [3:0] s);
    bus_wr(`OFS_SUM, d, s);
    for (int i = 0; i < 4; i++)
      if (s[i])
        feed(d[8*i+:8]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] v;
    bus_rd(`OFS_CONTROL, v);
    chk("control", v, 32'h0);
    bus_rd(`OFS_SEED, v);
    chk("seed", v, `SEED_RESET);
    mode(8'h01);
    bus_rd(`OFS_SUM, v);
    chk("sum", v, 32'h0000ffff);
  endtask

  task automatic t_refuse();
    logic [31:0] v;
    bus_wr(8'h0c, 32'h5a5a5a5a, 4'hf);
    bus_rd(8'h0c, v);
    chk("unmapped", v, 32'h0);
    m_seed = 32'ha5a51234;
    bus_wr(`OFS_SEED, m_seed, 4'hf);
    dw(32'h11223344, 4'hf);
    bus_rd(`OFS_SEED, v);
    chk("seed kept", v, m_seed);
    mode(8'hc1);
    bus_rd(`OFS_CONTROL, v);
    chk("control", v, 32'h41);
  endtask

  task automatic t_poly();
    logic [31:0] v;
    for (int s = 0; s < 2; s++)
      for (int p = 0; p < 4; p++)
      begin
        mode({1'b1, s[0], 4'h0, p[1:0]});
        dw(32'hc3a51e69, 4'hf);
        bus_rd(`OFS_SUM, v);
        chk("poly sum", v, sum_exp());
      end
  endtask

  task automatic t_modes();
    logic [31:0] v;
    for (int m = 0; m < 16; m++)
    begin
      mode({2'b10, m[3:0], m[0] ? 2'b01 : 2'b11});
      dw(32'h8d31f046, 4'hf);
      bus_rd(`OFS_SUM, v);
      chk("mode sum", v, sum_exp());
      dw(32'h0000005a, 4'h1);
      bus_rd(`OFS_SUM, v);
      chk("continued sum", v, sum_exp());
    end
  endtask

  // back to back writes, read issued at once and held off
  task automatic t_widths();
    logic [31:0] v;
    logic [3:0]  s [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
    mode(8'hc2);
    foreach (s[i])
      dw(32'h7e19b2d4 + 32'(i), s[i]);
    bus_rd(`OFS_SUM, v);
    chk("width sum", v, sum_exp());
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    nrst = 1'b0;
    n_errors = 0;
    tests_run = 0;
    m_rem = `SUM_RESET;
    m_seed = `SEED_RESET;
    m_ctrl = 8'h00;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_refuse();
    t_poly();
    t_modes();
    t_widths();
    wrap_up();
  end

  // whole run needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    wrap_up();
  end
endmodule
